// >>> src/vdc_pkg.sv
// Package for the supply trip detector control block.
// Assumes an APB slave with 32-bit data and a synchronous active-high reset.
package vdc_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] MASK_OFFSET = 8'h08;
  localparam logic [7:0] LEVEL_OFFSET = 8'h0c;
  // ------------------------------------------------------------
  // Control register fields and reset value
  // ------------------------------------------------------------
  localparam int DIR_BIT = 7;
  localparam int UNUSED_BIT = 6;
  localparam int STABLE_BIT = 5;
  localparam int ENABLE_BIT = 4;
  localparam int LEVEL_MSB = 3;
  localparam logic [7:0] CTRL_RESET = 8'h05;
  localparam logic [7:0] CTRL_WMASK = 8'h9f;
  localparam logic [3:0] EXT_PIN_CODE = 4'hf;
  // ------------------------------------------------------------
  // Status bits
  // ------------------------------------------------------------
  localparam int TRIP_BIT = 0;
  localparam int STABLE_EV_BIT = 1;
  localparam int NUM_EVENTS = 2;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int SETTLE_NS = 20000;
  localparam int CLK_NS = 100;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {VDC_OFF, VDC_SETTLE, VDC_READY} vdc_state_t;
endpackage

// >>> src/vdc_sync.sv
// Two-stage synchroniser for the comparator output.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module vdc_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Data
  input wire logic d_in,
  output logic q_out
);
  logic stage1_reg;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage1_reg <= 1'b0;
      q_out <= 1'b0;
    end else begin
      stage1_reg <= d_in;
      q_out <= stage1_reg;
    end
  end
endmodule

// >>> src/vdc_top.sv
// Control, settling and event logic around a supply trip detector.
// Assumes an APB master on core_clk and an analog comparator modelled as input.
`timescale 1ns/1ps
// Functional notes
// - Detector powered and trips produced only while enable bit is one.
// - Each enable restarts settling; stable flag low until settling ends.
// - Stable flag is read-only; reads return current stability.
// - No trip flag before stable flag rises after latest enable.
// - Direction clear: supply falling below trip point is the event.
// - Direction set: supply rising above trip point is the event.
// - Crossing in configured direction sets the trip interrupt flag.
// - Unmasked set flag raises the interrupt request.
// - Four-bit level selects threshold; one code selects external pin.
// - Bit 6 reads zero and ignores writes.
module vdc_top #(
  parameter int SETTLE_COUNT = vdc_pkg::SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog side
  input wire logic supply_above_trip,
  input wire logic ref_settled,
  output logic detector_power,
  output logic [3:0] trip_level_select,
  output logic use_external_sense_pin,
  // Interrupt
  output logic irq
);
  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic [1:0] status_next;
  logic [7:0] ctrl_next;
  logic [1:0] mask_next;
  logic [1:0] event_set;
  logic [1:0] clear_bits;
  // ------------------------------------------------------------
  // Bus and settling state
  // ------------------------------------------------------------
  logic [31:0] read_word;
  logic access_phase;
  logic access_done;
  logic write_done;
  logic read_done;
  logic addr_known;
  localparam int CNT_W = $clog2(SETTLE_COUNT + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE_COUNT - 1);
  vdc_pkg::vdc_state_t state_reg;
  vdc_pkg::vdc_state_t state_next;
  logic [CNT_W-1:0] settle_cnt_reg;
  logic enable;
  logic stable;
  logic above_sync;
  logic trip_cond;
  logic cond_prev_reg;
  logic trip_event;
  genvar gi;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

  function automatic logic is_ext(input logic [3:0] level);
    return level == vdc_pkg::EXT_PIN_CODE;
  endfunction

  function automatic logic [7:0] ctrl_view(input logic [7:0] stored, input logic stable_now);
    logic [7:0] view;
    view = stored & vdc_pkg::CTRL_WMASK;
    view[vdc_pkg::STABLE_BIT] = stable_now;
    view[vdc_pkg::UNUSED_BIT] = 1'h0;
    return view;
  endfunction

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  assign access_phase = psel && penable && !pready;
  assign access_done = psel && penable && pready;
  assign write_done = access_done && pwrite;
  assign read_done = access_done && !pwrite;
  assign addr_known = addr_is(paddr, vdc_pkg::CTRL_OFFSET) ||
    addr_is(paddr, vdc_pkg::STATUS_OFFSET) ||
    addr_is(paddr, vdc_pkg::MASK_OFFSET) ||
    addr_is(paddr, vdc_pkg::LEVEL_OFFSET);

  always_comb begin
    read_word = 32'h0000_0000;
    if (addr_is(paddr, vdc_pkg::CTRL_OFFSET)) begin
      read_word[7:0] = ctrl_view(ctrl_reg, stable);
    end else if (addr_is(paddr, vdc_pkg::STATUS_OFFSET)) begin
      read_word[1:0] = status_reg;
    end else if (addr_is(paddr, vdc_pkg::MASK_OFFSET)) begin
      read_word[1:0] = mask_reg;
    end else if (addr_is(paddr, vdc_pkg::LEVEL_OFFSET)) begin
      read_word[vdc_pkg::LEVEL_MSB:0] = ctrl_reg[vdc_pkg::LEVEL_MSB:0];
    end
  end

  // The slave inserts one wait state, so read data stands when pready is high.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready <= 1'h0;
      pslverr <= 1'h0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access_phase;
      pslverr <= access_phase && !addr_known;
      if (access_phase && !pwrite) begin
        prdata <= read_word;
      end
    end
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    if (write_done && addr_is(paddr, vdc_pkg::CTRL_OFFSET)) begin
      ctrl_next = pwdata[7:0] & vdc_pkg::CTRL_WMASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg <= vdc_pkg::CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      detector_power <= vdc_pkg::CTRL_RESET[vdc_pkg::ENABLE_BIT];
      trip_level_select <= vdc_pkg::CTRL_RESET[vdc_pkg::LEVEL_MSB:0];
      use_external_sense_pin <= is_ext(vdc_pkg::CTRL_RESET[vdc_pkg::LEVEL_MSB:0]);
    end else begin
      detector_power <= ctrl_next[vdc_pkg::ENABLE_BIT];
      trip_level_select <= ctrl_next[vdc_pkg::LEVEL_MSB:0];
      use_external_sense_pin <= is_ext(ctrl_next[vdc_pkg::LEVEL_MSB:0]);
    end
  end

  // ------------------------------------------------------------
  // Interrupt mask
  // ------------------------------------------------------------
  always_comb begin
    mask_next = mask_reg;
    if (write_done && addr_is(paddr, vdc_pkg::MASK_OFFSET)) begin
      mask_next = pwdata[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask_reg <= 2'h0;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // ------------------------------------------------------------
  // Settling sequence
  // ------------------------------------------------------------
  assign enable = ctrl_reg[vdc_pkg::ENABLE_BIT];
  assign stable = state_reg == vdc_pkg::VDC_READY;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      vdc_pkg::VDC_OFF: begin
        if (enable) begin
          state_next = vdc_pkg::VDC_SETTLE;
        end
      end
      vdc_pkg::VDC_SETTLE: begin
        if (!enable) begin
          state_next = vdc_pkg::VDC_OFF;
        end else if (settle_cnt_reg == CNT_LAST && ref_settled) begin
          state_next = vdc_pkg::VDC_READY;
        end
      end
      vdc_pkg::VDC_READY: begin
        if (!enable) begin
          state_next = vdc_pkg::VDC_OFF;
        end
      end
      default: begin
        state_next = vdc_pkg::VDC_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= vdc_pkg::VDC_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      settle_cnt_reg <= '0;
    end else if (state_reg != vdc_pkg::VDC_SETTLE) begin
      settle_cnt_reg <= '0;
    end else if (settle_cnt_reg != CNT_LAST) begin
      settle_cnt_reg <= settle_cnt_reg + 1'h1;
    end
  end

  // ------------------------------------------------------------
  // Trip detection
  // ------------------------------------------------------------
  vdc_sync i_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d_in(supply_above_trip),
    .q_out(above_sync)
  );

  always_comb begin
    if (ctrl_reg[vdc_pkg::DIR_BIT]) begin
      trip_cond = above_sync;
    end else begin
      trip_cond = !above_sync;
    end
  end

  // Remembering the last condition makes a held excursion count only once.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cond_prev_reg <= 1'h0;
    end else begin
      cond_prev_reg <= stable && trip_cond;
    end
  end

  assign trip_event = enable && stable &&
    trip_cond && !cond_prev_reg;

  // ------------------------------------------------------------
  // Event status
  // ------------------------------------------------------------
  always_comb begin
    event_set = 2'h0;
    event_set[vdc_pkg::TRIP_BIT] = trip_event;
    event_set[vdc_pkg::STABLE_EV_BIT] = state_next == vdc_pkg::VDC_READY && !stable;
  end

  always_comb begin
    clear_bits = 2'h0;
    if (read_done && addr_is(paddr, vdc_pkg::STATUS_OFFSET)) begin
      clear_bits = prdata[1:0];
    end
  end

  // Only the bits that the read returned are cleared, and a new event wins.
  generate
    for (gi = 0; gi < vdc_pkg::NUM_EVENTS; gi = gi + 1) begin : g_status
      assign status_next[gi] = event_set[gi] | (status_reg[gi] & !clear_bits[gi]);
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_reg <= 2'h0;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'h0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  power_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    trip_event |-> detector_power && enable)
    else $error("trip event while the detector is off");

  settle_restart_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(enable) |-> !stable)
    else $error("stable flag high at a fresh enable");

  stable_view_a: assert property (@(posedge core_clk) disable iff (rst)
    access_phase && !pwrite && addr_is(paddr, vdc_pkg::CTRL_OFFSET) |=>
    prdata[vdc_pkg::STABLE_BIT] == $past(stable))
    else $error("stable bit read back wrongly");

  trip_gated_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(status_reg[vdc_pkg::TRIP_BIT]) |-> $past(stable))
    else $error("trip flag set before settling ended");

  irq_follows_a: assert property (@(posedge core_clk) disable iff (rst)
    irq == $past(|(status_reg & mask_reg)))
    else $error("interrupt does not follow the unmasked flags");

  ext_code_a: assert property (@(posedge core_clk) disable iff (rst)
    use_external_sense_pin == is_ext(trip_level_select))
    else $error("external sense select does not match the level code");

  unused_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    pready |-> !prdata[vdc_pkg::UNUSED_BIT])
    else $error("unused control bit reads as one");

  flag_held_a: assert property (@(posedge core_clk) disable iff (rst)
    status_reg[vdc_pkg::TRIP_BIT] && !clear_bits[vdc_pkg::TRIP_BIT] |=>
    status_reg[vdc_pkg::TRIP_BIT])
    else $error("trip flag dropped without a clearing read");
endmodule

// >>> tb/vdc_ana.sv
// Comparator and reference model.
// Assumes one clock.
`timescale 1ns/1ps
module vdc_ana (input wire logic core_clk, input wire logic pwr, input wire logic hi,
  output logic ok, output logic cmp);
  logic [2:0] n = 0;
  always @(posedge core_clk) n <= pwr ? n + 3'(n < 3) : 3'h0;
  always @(posedge core_clk) cmp <= pwr ? hi : cmp !== 1'b1;
  assign ok = n == 3'h3;
endmodule

// >>> tb/voltage_detect_control_test.sv
// Bench for the trip detector block.
// Assumes vdc_top and vdc_ana.
`timescale 1ns/1ps
module voltage_detect_control_test;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, hi = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, ok, cmp, pwr, ext, irq;
  logic [3:0] lvl;
  int err_total = 0, tests_run = 0, cyc = 0;
  vdc_top #(.SETTLE_COUNT(4)) i_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr(), .supply_above_trip(cmp), .ref_settled(ok),
    .detector_power(pwr), .trip_level_select(lvl), .use_external_sense_pin(ext), .irq);
  vdc_ana i_ana (.core_clk, .pwr, .hi, .ok, .cmp);
  initial forever #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc == 3000) begin err_total++; conclude(); end
  task automatic chk(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin err_total++; $display("[ERR] %0t got %h", $time, g); end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic rdy;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk) penable <= 1;
    do begin
      @(negedge core_clk) rdy = pready;
      q = prdata;
      @(posedge core_clk);
    end while (rdy !== 1);
    psel <= 0; penable <= 0;
    @(posedge core_clk);
  endtask
  task automatic conclude();
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_regs();
    apb(0, vdc_pkg::CTRL_OFFSET, 0);
    chk(q, 32'h05);
    apb(1, vdc_pkg::CTRL_OFFSET, 32'hff);
    apb(0, vdc_pkg::CTRL_OFFSET, 0);
    chk(q, 32'h9f);
    chk({ext, lvl, pwr}, 32'h3f);
  endtask
  task automatic t_trip();
    for (int i = 0; i < 40 && q[5] !== 1; i++) apb(0, vdc_pkg::CTRL_OFFSET, 0);
    chk(q, 32'hbf);
    apb(1, vdc_pkg::MASK_OFFSET, 1);
    apb(0, vdc_pkg::STATUS_OFFSET, 0);
    hi <= 1;
    repeat (6) @(posedge core_clk);
    chk(irq, 1);
    apb(0, vdc_pkg::STATUS_OFFSET, 0);
    chk(q[0], 1);
    @(posedge core_clk);
    chk(irq, 0);
    apb(0, vdc_pkg::STATUS_OFFSET, 0);
    chk(q, 0);
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    t_regs();
    t_trip();
    conclude();
  end
endmodule
